// file: irqc_pkg.sv
/*
 * Constants for the interrupt command and debug register slice: register
 * byte offsets, field positions, reset values and bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
 */
package irqc_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int ADDR_W = 12; // Byte address width of the register window.
    localparam int NSRC = 32; // Number of interrupt sources.
    localparam int IDX_W = 5; // Width of a source number.

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFF_VEC_LAST = 12'h07C; // Source vectors sit from 0x000 up to here.
    localparam logic [11:0] OFF_NORMAL_VEC = 12'h100; // Normal vector readout.
    localparam logic [11:0] OFF_FAST_VEC = 12'h104; // Fast vector readout.
    localparam logic [11:0] OFF_CUR_ID = 12'h108; // Current in-service source number.
    localparam logic [11:0] OFF_PENDING = 12'h10C; // Pending flags.
    localparam logic [11:0] OFF_ENABLE = 12'h110; // Per-source enable mask.
    localparam logic [11:0] OFF_CLEAR = 12'h114; // Source clear command.
    localparam logic [11:0] OFF_SET = 12'h118; // Source set command.
    localparam logic [11:0] OFF_EOS = 12'h11C; // End-of-service command.
    localparam logic [11:0] OFF_SPURIOUS = 12'h120; // Spurious vector.
    localparam logic [11:0] OFF_DEBUG = 12'h124; // Debug control.
    localparam logic [11:0] OFF_EV_STATUS = 12'h128; // Sticky event status, write one to clear.
    localparam logic [11:0] OFF_EV_MASK = 12'h12C; // Event interrupt mask.
    localparam logic [11:0] OFF_CORE_STAT = 12'h130; // Request line status.

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int DBG_PROTECTION_ENABLE_BIT = 0; // Protection enable.
    localparam int DBG_GLOBAL_REQUEST_MASK_BIT = 1; // Global request mask.
    localparam int FAST_SRC = 0; // Fast source number.
    localparam int NEV = 3; // Number of event bits.
    localparam int EV_SPU_NORMAL = 0; // Normal readout found nothing to serve.
    localparam int EV_SPU_FAST = 1; // Fast readout found nothing to serve.
    localparam int EV_EOS_IDLE = 2; // End-of-service with nothing in service.
    localparam logic [31:0] SPURIOUS_RST = 32'h0000_0000;
    localparam logic [1:0] DEBUG_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irqc_pkg

// file: irqc_top.sv
/*
 * Command, spurious-vector and debug register slice of a vectored interrupt
 * controller, with its pending flags, nesting stack and request lines.
 * Assumes an AXI4-Lite master on SYS_CLK and source lines that are
 * asynchronous to it; every source is taken as rising-edge triggered.
 */
`timescale 1ns/1ns
module irqc_top (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] SRC_IN,
    output logic NORMAL_REQUEST_LINE_N,
    output logic FAST_REQUEST_LINE_N,
    output logic IRQ_OUT
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [31:0] src_s1, src_s2, src_s3; // Source synchroniser and edge stage.
    logic [31:0] pending; // Pending flags.
    logic [31:0] enable; // Per-source enable mask.
    logic [31:0] in_service; // Nesting stack, one bit per source.
    logic [31:0] spurious; // Spurious vector.
    logic [1:0] debug; // Debug control bits.
    logic [31:0] vectors [irqc_pkg::NSRC]; // Source vectors.
    logic [irqc_pkg::NEV-1:0] ev_status; // Sticky events.
    logic [irqc_pkg::NEV-1:0] ev_mask; // Event mask.
    logic aw_full, w_full; // Address or data held while waiting for the other.
    logic [11:0] addr_q;
    logic [31:0] data_q;
    logic [3:0] strb_q;

    // ****************************************************************
    // Write channel decode
    // ****************************************************************
    logic aw_take, w_take, wr_do, next_aw_full, next_w_full, next_b_valid;
    logic [11:0] wa;
    logic [31:0] wd, wm, wbits;
    logic wr_ok, we_vec, we_clear, we_set, we_eos, we_spu, we_dbg, we_en, we_evs, we_evm, we_ivr;
    logic [31:0] clr_bits, set_bits, src_edge;
    assign aw_take = AWVALID & AWREADY;
    assign w_take = WVALID & WREADY;
    assign wr_do = (aw_full | aw_take) & (w_full | w_take);
    assign wa = aw_full ? addr_q : AWADDR;
    assign wd = w_full ? data_q : WDATA;
    assign wm = {{8{(w_full ? strb_q[3] : WSTRB[3])}}, {8{(w_full ? strb_q[2] : WSTRB[2])}},
                 {8{(w_full ? strb_q[1] : WSTRB[1])}}, {8{(w_full ? strb_q[0] : WSTRB[0])}}};
    assign wbits = wd & wm;
    assign next_aw_full = (aw_full | aw_take) & ~wr_do;
    assign next_w_full = (w_full | w_take) & ~wr_do;
    assign next_b_valid = wr_do | (BVALID & ~BREADY);
    assign we_vec = wr_do && (wa <= irqc_pkg::OFF_VEC_LAST);
    assign we_clear = wr_do && (wa == irqc_pkg::OFF_CLEAR);
    assign we_set = wr_do && (wa == irqc_pkg::OFF_SET);
    assign we_eos = wr_do && (wa == irqc_pkg::OFF_EOS);
    assign we_spu = wr_do && (wa == irqc_pkg::OFF_SPURIOUS);
    assign we_dbg = wr_do && (wa == irqc_pkg::OFF_DEBUG);
    assign we_en = wr_do && (wa == irqc_pkg::OFF_ENABLE);
    assign we_evs = wr_do && (wa == irqc_pkg::OFF_EV_STATUS);
    assign we_evm = wr_do && (wa == irqc_pkg::OFF_EV_MASK);
    assign we_ivr = wr_do && (wa == irqc_pkg::OFF_NORMAL_VEC);
    // Writable locations answer OKAY; read-only and unmapped ones answer SLVERR.
    assign wr_ok = (wa[1:0] == 2'h0) && ((wa <= irqc_pkg::OFF_VEC_LAST) || (wa == irqc_pkg::OFF_CLEAR)
                   || (wa == irqc_pkg::OFF_SET) || (wa == irqc_pkg::OFF_EOS) || (wa == irqc_pkg::OFF_SPURIOUS)
                   || (wa == irqc_pkg::OFF_DEBUG) || (wa == irqc_pkg::OFF_ENABLE)
                   || (wa == irqc_pkg::OFF_EV_STATUS) || (wa == irqc_pkg::OFF_EV_MASK)
                   || (wa == irqc_pkg::OFF_NORMAL_VEC));
    assign clr_bits = we_clear ? wbits : 32'h0000_0000;
    assign set_bits = we_set ? wbits : 32'h0000_0000;
    assign src_edge = src_s2 & ~src_s3;

    // ****************************************************************
    // Priority resolution
    // ****************************************************************
    // Higher source number means higher priority; only a source above the
    // top of the nesting stack may raise the normal line.
    logic [4:0] top, best;
    logic top_valid, best_valid, fast_act, protection_enable, global_request_mask;
    logic [31:0] cand;
    assign protection_enable = debug[irqc_pkg::DBG_PROTECTION_ENABLE_BIT];
    assign global_request_mask = debug[irqc_pkg::DBG_GLOBAL_REQUEST_MASK_BIT];
    assign cand = pending & enable;
    assign fast_act = cand[irqc_pkg::FAST_SRC];
    always_comb begin
        top = 5'h00;
        top_valid = 1'b0;
        best = 5'h00;
        best_valid = 1'b0;
        for (int i = 1; i < irqc_pkg::NSRC; i++) begin
            if (in_service[i]) begin
                top = i[4:0];
                top_valid = 1'b1;
            end
        end
        for (int i = 1; i < irqc_pkg::NSRC; i++) begin
            if (cand[i] && (i[4:0] > top)) begin
                best = i[4:0];
                best_valid = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Read decode and acknowledge
    // ****************************************************************
    logic rd_take, rd_ok, rd_ivr, rd_fvr, push;
    logic [31:0] rd_value, push_mask, pop_mask;
    logic [irqc_pkg::NEV-1:0] ev_set;
    assign rd_take = ARVALID & ARREADY;
    assign rd_ivr = rd_take && (ARADDR == irqc_pkg::OFF_NORMAL_VEC);
    assign rd_fvr = rd_take && (ARADDR == irqc_pkg::OFF_FAST_VEC);
    // In protection mode a read changes only the sticky spurious events, so a debugger may look
    // freely; software then acknowledges by writing the readout register.
    assign push = best_valid && ((rd_ivr && !protection_enable) || (we_ivr && protection_enable));
    assign push_mask = push ? (32'h0000_0001 << best) : 32'h0000_0000;
    assign pop_mask = (we_eos && top_valid) ? (32'h0000_0001 << top) : 32'h0000_0000;
    assign ev_set = {we_eos && !top_valid, rd_fvr && !fast_act, rd_ivr && !best_valid};
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_ok = 1'b1;
        if (ARADDR[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (ARADDR <= irqc_pkg::OFF_VEC_LAST) begin
            rd_value = vectors[ARADDR[6:2]];
        end else begin
            case (ARADDR)
                irqc_pkg::OFF_NORMAL_VEC: rd_value = best_valid ? vectors[best] : spurious;
                irqc_pkg::OFF_FAST_VEC: rd_value = fast_act ? vectors[irqc_pkg::FAST_SRC] : spurious;
                irqc_pkg::OFF_CUR_ID: rd_value = {27'h0000000, top};
                irqc_pkg::OFF_PENDING: rd_value = pending;
                irqc_pkg::OFF_ENABLE: rd_value = enable;
                irqc_pkg::OFF_CLEAR, irqc_pkg::OFF_SET, irqc_pkg::OFF_EOS: rd_value = 32'h0000_0000;
                irqc_pkg::OFF_SPURIOUS: rd_value = spurious;
                irqc_pkg::OFF_DEBUG: rd_value = {30'h00000000, debug};
                irqc_pkg::OFF_EV_STATUS: rd_value = {29'h00000000, ev_status};
                irqc_pkg::OFF_EV_MASK: rd_value = {29'h00000000, ev_mask};
                irqc_pkg::OFF_CORE_STAT: rd_value = {30'h00000000, ~NORMAL_REQUEST_LINE_N, ~FAST_REQUEST_LINE_N};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite write channels
    // ****************************************************************
    // Address and data are held separately so either may come first; no new
    // beat is taken while a response is outstanding.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            addr_q <= 12'h000;
            data_q <= 32'h0000_0000;
            strb_q <= 4'h0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= irqc_pkg::RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            if (aw_take) begin
                addr_q <= AWADDR;
            end
            if (w_take) begin
                data_q <= WDATA;
                strb_q <= WSTRB;
            end
            AWREADY <= ~next_aw_full & ~next_b_valid;
            WREADY <= ~next_w_full & ~next_b_valid;
            BVALID <= next_b_valid;
            if (wr_do) begin
                BRESP <= wr_ok ? irqc_pkg::RESP_OKAY : irqc_pkg::RESP_SLVERR;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels
    // ****************************************************************
    // Data is registered at the edge the address is taken, so it answers
    // one cycle later and the readout side effects happen once.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= irqc_pkg::RESP_OKAY;
        end else if (rd_take) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_ok ? rd_value : 32'h0000_0000;
            RRESP <= rd_ok ? irqc_pkg::RESP_OKAY : irqc_pkg::RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end else begin
            ARREADY <= ~RVALID;
        end
    end

    // ****************************************************************
    // Source synchroniser
    // ****************************************************************
    // Only the second stage is looked at; the third gives the edge.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            src_s1 <= 32'h0000_0000;
            src_s2 <= 32'h0000_0000;
            src_s3 <= 32'h0000_0000;
        end else begin
            src_s1 <= SRC_IN;
            src_s2 <= src_s1;
            src_s3 <= src_s2;
        end
    end

    // ****************************************************************
    // Pending flags and nesting stack
    // ****************************************************************
    // Set command and source edges win over a clear in the same cycle.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pending <= 32'h0000_0000;
            in_service <= 32'h0000_0000;
        end else begin
            pending <= (pending & ~clr_bits & ~push_mask) | set_bits | src_edge;
            in_service <= (in_service & ~pop_mask) | push_mask;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            spurious <= irqc_pkg::SPURIOUS_RST;
            debug <= irqc_pkg::DEBUG_RST;
            enable <= 32'h0000_0000;
            ev_mask <= '0;
            for (int i = 0; i < irqc_pkg::NSRC; i++) begin
                vectors[i] <= 32'h0000_0000;
            end
        end else begin
            if (we_spu) begin
                spurious <= (spurious & ~wm) | wbits;
            end
            if (we_dbg) begin
                debug <= (debug & ~wm[1:0]) | wbits[1:0];
            end
            if (we_en) begin
                enable <= (enable & ~wm) | wbits;
            end
            if (we_evm) begin
                ev_mask <= (ev_mask & ~wm[irqc_pkg::NEV-1:0]) | wbits[irqc_pkg::NEV-1:0];
            end
            if (we_vec) begin
                vectors[wa[6:2]] <= (vectors[wa[6:2]] & ~wm) | wbits;
            end
        end
    end

    // ****************************************************************
    // Event status and interrupt output
    // ****************************************************************
    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ev_status <= '0;
            IRQ_OUT <= 1'b0;
        end else begin
            ev_status <= (ev_status & ~(we_evs ? wbits[irqc_pkg::NEV-1:0] : '0)) | ev_set;
            IRQ_OUT <= |(ev_status & ev_mask);
        end
    end

    // ****************************************************************
    // Request lines
    // ****************************************************************
    // Lines are active low and lag the pending state by one cycle.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            NORMAL_REQUEST_LINE_N <= 1'b1;
            FAST_REQUEST_LINE_N <= 1'b1;
        end else begin
            NORMAL_REQUEST_LINE_N <= ~(best_valid & ~global_request_mask);
            FAST_REQUEST_LINE_N <= ~(fast_act & ~global_request_mask);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_write_done;
        wr_do ##1 BVALID;
    endsequence
    a_write_answer: assert property (@(posedge SYS_CLK) disable iff (!RST_N) wr_do |-> s_write_done)
        else $error("write not answered");
    a_clear_cmd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        we_clear |=> ((pending & $past(clr_bits) & ~$past(src_edge) & ~$past(set_bits)) == 32'h0000_0000))
        else $error("clear command left source pending");
    a_set_cmd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        we_set |=> ((pending & $past(set_bits)) == $past(set_bits)))
        else $error("set command did not set source");
    a_cmd_read_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_take && (ARADDR == irqc_pkg::OFF_SET || ARADDR == irqc_pkg::OFF_CLEAR) |=> RDATA == 32'h0000_0000)
        else $error("command register read not zero");
    a_eos_pop: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        we_eos && top_valid && !push |=> in_service == ($past(in_service) & ~$past(pop_mask)))
        else $error("end of service did not pop");
    a_spu_readback: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_ivr && !best_valid |=> RDATA == $past(spurious))
        else $error("spurious normal readout wrong");
    a_fast_spurious: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_fvr && !fast_act |=> RDATA == $past(spurious))
        else $error("spurious fast readout wrong");
    a_gmask_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        global_request_mask |=> NORMAL_REQUEST_LINE_N && FAST_REQUEST_LINE_N)
        else $error("request line active under global mask");
    a_line_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !global_request_mask && best_valid |=> !NORMAL_REQUEST_LINE_N)
        else $error("normal line not raised");
    a_protection_enable_noside: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        protection_enable && rd_ivr && !we_ivr && !we_eos |=> in_service == $past(in_service))
        else $error("protected read changed stack");
    a_pend_show: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_take && ARADDR == irqc_pkg::OFF_PENDING |=> RDATA == $past(pending))
        else $error("pending readout wrong");

endmodule : irqc_top

// file: irqc_core_model.sv
/*
 * Behavioural processor core that watches the two active-low request lines.
 * Assumes the lines come from flops on the same clock as this model.
 */
`timescale 1ns/1ns
// ****************
// Core model
// ****************
module irqc_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic normal_n,
    input wire logic fast_n,
    input wire logic clr,
    output logic normal_seen,
    output logic fast_seen
);
    // A real core samples the level on its clock, so a glitch between edges is never seen here either.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_seen <= 1'b0;
            fast_seen <= 1'b0;
        end else begin
            normal_seen <= (normal_seen & ~clr) | ~normal_n;
            fast_seen <= (fast_seen & ~clr) | ~fast_n;
        end
    end
endmodule : irqc_core_model

// file: irq_command_debug_regs_tb.sv
/*
 * Self-checking bench for the command and debug register slice.
 * Assumes the design answers AXI4-Lite requests and drives flopped request lines.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module irq_command_debug_regs_tb;
    // ****************
    // Signals
    // ****************
    typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} irqc_row_t;
    logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, clr = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, src = 0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, rs, wb;
    logic awready, wready, bvalid, arready, rvalid, nrq_n, frq_n, irq, nseen, fseen;
    int num_errors = 0, tests_run = 0;
    irqc_row_t rows [8];
    irqc_top dut (.SYS_CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .SRC_IN(src), .NORMAL_REQUEST_LINE_N(nrq_n),
        .FAST_REQUEST_LINE_N(frq_n), .IRQ_OUT(irq));
    irqc_core_model core (.clk(clk), .rst_n(rst_n), .normal_n(nrq_n), .fast_n(frq_n), .clr(clr),
        .normal_seen(nseen), .fast_seen(fseen));
    // Free-running 50 ns clock.
    always #25 clk = ~clk;
    // ****************
    // Bus tasks
    // ****************
    // Each channel drops its valid only at the edge where its ready was seen high.
    // The tasks wait as long as the design needs; only the watchdog ends a hang.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        wb = bresp;
        bready <= 0;
    endtask : wr
    task automatic rdx(input logic [11:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rd = rdata; rs = rresp; rready <= 0;
    endtask : rdx
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("tests %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        rows = '{'{irqc_pkg::OFF_SPURIOUS, 32'hA5A5_0004, irqc_pkg::OFF_SPURIOUS, 32'hA5A5_0004},
            '{irqc_pkg::OFF_DEBUG, 32'h0000_0003, irqc_pkg::OFF_DEBUG, 32'h0000_0003},
            '{irqc_pkg::OFF_DEBUG, 32'h0000_0000, irqc_pkg::OFF_DEBUG, 32'h0000_0000},
            '{irqc_pkg::OFF_ENABLE, 32'hFFFF_FFFF, irqc_pkg::OFF_CLEAR, 32'h0000_0000},
            '{irqc_pkg::OFF_SET, 32'h8000_0024, irqc_pkg::OFF_PENDING, 32'h8000_0024},
            '{irqc_pkg::OFF_CLEAR, 32'h8000_0004, irqc_pkg::OFF_PENDING, 32'h0000_0020},
            '{irqc_pkg::OFF_CLEAR, 32'h0000_0000, irqc_pkg::OFF_PENDING, 32'h0000_0020},
            '{irqc_pkg::OFF_CLEAR, 32'h0000_0020, irqc_pkg::OFF_SET, 32'h0000_0000}};
        repeat (16) @(posedge clk);
        rst_n <= 1;
        rdx(irqc_pkg::OFF_SPURIOUS); `CHK(rd, 32'h0)
        rdx(irqc_pkg::OFF_DEBUG); `CHK(rd, 32'h0)
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rdx(rows[i].ra); `CHK(rd, rows[i].ex)
        end
        $display("table done");
        // Only the lowest byte lane is enabled, so the upper bytes must keep their value.
        wstrb <= 4'h1;
        wr(irqc_pkg::OFF_SPURIOUS, 32'hFFFF_FF10);
        wstrb <= 4'hF;
        rdx(irqc_pkg::OFF_SPURIOUS); `CHK(rd, 32'hA5A5_0010)
        // Forget what the core saw during the table, so the next check means something.
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        @(posedge clk);
        `CHK({nseen, fseen}, 2'h0)
        wr(12'h014, 32'h0000_1230);
        wr(irqc_pkg::OFF_SET, 32'h0000_0021);
        repeat (3) @(posedge clk);
        `CHK({nseen, fseen}, 2'h3)
        wr(irqc_pkg::OFF_DEBUG, 32'h0000_0002);
        repeat (3) @(posedge clk);
        `CHK({nrq_n, frq_n}, 2'h3)
        wr(irqc_pkg::OFF_DEBUG, 32'h0000_0000);
        wr(irqc_pkg::OFF_CLEAR, 32'h0000_0001);
        rdx(irqc_pkg::OFF_NORMAL_VEC); `CHK(rd, 32'h0000_1230)
        rdx(irqc_pkg::OFF_CUR_ID); `CHK(rd, 32'h0000_0005)
        rdx(irqc_pkg::OFF_NORMAL_VEC); `CHK(rd, 32'hA5A5_0010)
        rdx(irqc_pkg::OFF_FAST_VEC); `CHK(rd, 32'hA5A5_0010)
        $display("vector done");
        wr(irqc_pkg::OFF_EV_MASK, 32'h0000_0003);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(irqc_pkg::OFF_EV_STATUS, 32'h0000_0003);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(irqc_pkg::OFF_EOS, 32'hDEAD_BEEF);
        rdx(irqc_pkg::OFF_CUR_ID); `CHK(rd, 32'h0)
        // Protection mode: a readout neither pushes the stack nor clears pending; a write to it acknowledges.
        wr(irqc_pkg::OFF_DEBUG, 32'h0000_0001);
        wr(irqc_pkg::OFF_SET, 32'h0000_0020);
        rdx(irqc_pkg::OFF_NORMAL_VEC); `CHK(rd, 32'h0000_1230)
        rdx(irqc_pkg::OFF_CUR_ID); `CHK(rd, 32'h0)
        wr(irqc_pkg::OFF_NORMAL_VEC, 32'h0000_0000);
        rdx(irqc_pkg::OFF_CUR_ID); `CHK(rd, 32'h0000_0005)
        wr(irqc_pkg::OFF_EOS, 32'h0000_0000);
        rdx(12'h200); `CHK(rs, irqc_pkg::RESP_SLVERR)
        src <= 32'h0000_0200;
        repeat (6) @(posedge clk);
        rdx(irqc_pkg::OFF_PENDING); `CHK(rd, 32'h0000_0200)
        // A write to the read-only pending flags is refused and leaves them alone.
        wr(irqc_pkg::OFF_PENDING, 32'hFFFF_FFFF); `CHK(wb, irqc_pkg::RESP_SLVERR)
        rdx(irqc_pkg::OFF_PENDING); `CHK(rd, 32'h0000_0200)
        // A second reset in mid-run must bring the debug and spurious registers back to zero.
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rdx(irqc_pkg::OFF_DEBUG); `CHK(rd, 32'h0)
        rdx(irqc_pkg::OFF_SPURIOUS); `CHK(rd, 32'h0)
        $display("service done");
        summarize();
    end
endmodule : irq_command_debug_regs_tb
